// ==== logic/aes_flags.sv ====
// What this block does
// - Nondata config plus active transfer sets flag0
// - Packet data phase violation sets flag1
// - Violation between A0h and packet sets flag2
// - Busy at launch sets flag3, blocks command in automatic command mode
// - Status bits 3:1 mirror DMA and interrupt pins
// - Drive moving excess data sets overrun bit
// - Overrun also raises byte count mismatch
// - PIO auto: interrupt then DRQ sets overrun
// - UDMA read overrun pauses and terminates burst
// - Overrun set only if DMARQ returns first
// - Overrun cleared by write one or launch
// - Secondary flags upper nibble reads zero
// - Byte count mismatch flagged to primary logic
// - Pending output shows enabled secondary flags
// - Flags interrupt only where mask bit set
module aes_flags (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // MCU data space access
  input  wire logic [15:0] xaddr_i,
  input  wire logic        xwr_i,
  input  wire logic        xrd_i,
  input  wire logic [7:0]  xwdata_i,
  output logic      [7:0]  xrdata_o,
  // Drive pins
  input  wire logic        dmarq_i,
  input  wire logic        dmack_n_i,
  input  wire logic        intrq_i,
  // Sequencer events and modes
  input  wire logic        command_launch_i,
  input  wire logic        auto_cmd_mode_i,
  input  wire logic        drive_busy_i,
  input  wire logic        nondata_cfg_i,
  input  wire logic        cmd_issue_i,
  input  wire logic        drive_data_active_i,
  input  wire logic        packet_mode_i,
  input  wire logic        full_auto_i,
  input  wire logic        data_phase_i,
  input  wire logic        seq_violation_i,
  input  wire logic        cmd_wr_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic        packet_sent_i,
  input  wire logic        length_exceeded_i,
  input  wire logic        xfer_mismatch_i,
  input  wire logic        pio_auto_i,
  input  wire logic        status_rd_i,
  input  wire logic        status_drq_i,
  input  wire logic        udma_read_i,
  input  wire logic        udma_overrun_i,
  // Results
  output logic             launch_go_o,
  output logic             byte_count_mismatch_o,
  output logic             secondary_pending_o,
  output logic             irq_o,
  output logic             udma_pause_o,
  output logic             udma_stop_o
);
  import aes_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] sy3;
    logic [2:0] pin;
    logic [3:0] flags;
    logic [3:0] mask;
    logic       ovr;
    logic       pkt_wait;
    logic       intrq_seen;
    aes_ud_t    ud;
    logic [7:0] rdata;
    logic       mis;
    logic       go;
  } aes_state_t;

  aes_state_t q;
  aes_state_t d;

  logic [3:0] set_v;
  logic [3:0] clr_v;
  logic       ovr_set;
  logic       ovr_clr;
  logic       pin_ok;

  // Next state
  always_comb begin
    d = q;
    // Pin synchronisers, change taken once stages two and three agree
    d.sy1 = {intrq_i, dmack_n_i, dmarq_i};
    d.sy2 = q.sy1;
    d.sy3 = q.sy2;
    pin_ok = (q.sy2 == q.sy3);
    if (pin_ok) begin
      d.pin = q.sy2;
    end

    // Window between packet command write and packet bytes
    if (packet_sent_i || command_launch_i) begin
      d.pkt_wait = 1'b0;
    end
    if (cmd_wr_i && packet_mode_i && full_auto_i && cmd_code_i == PACKET_CMD) begin
      d.pkt_wait = 1'b1;
    end

    // Secondary flag events
    set_v = 4'h0;
    set_v[BIT_NDA]  = nondata_cfg_i && cmd_issue_i && drive_data_active_i;
    set_v[BIT_DSEQ] = packet_mode_i && data_phase_i && seq_violation_i;
    set_v[BIT_SEQ]  = packet_mode_i && full_auto_i && q.pkt_wait
                      && seq_violation_i;
    set_v[BIT_BSY]  = command_launch_i && drive_busy_i;

    // Write one to clear, set wins
    clr_v = 4'h0;
    if (xwr_i && xaddr_i == ADDR_FLAGS) begin
      clr_v = xwdata_i[3:0];
    end
    d.flags = (q.flags & ~clr_v) | set_v;

    // Mask register
    if (xwr_i && xaddr_i == ADDR_MASK) begin
      d.mask = xwdata_i[3:0];
    end

    // Command proceeds unless busy in automatic command mode
    d.go = command_launch_i && !(drive_busy_i && auto_cmd_mode_i);

    // PIO auto: interrupt seen, later status read with DRQ
    if (command_launch_i || !pio_auto_i) begin
      d.intrq_seen = 1'b0;
    end else if (q.pin[PIN_INTRQ]) begin
      d.intrq_seen = 1'b1;
    end
    ovr_set = length_exceeded_i;
    if (pio_auto_i && q.intrq_seen && status_rd_i && status_drq_i) begin
      ovr_set = 1'b1;
    end

    // UDMA read overrun: pause, wait DMARQ drop, then watch
    case (q.ud)
      UD_IDLE: begin
        if (udma_read_i && udma_overrun_i) begin
          d.ud = UD_PAUSE;
        end
      end
      UD_PAUSE: begin
        if (q.pin[PIN_INTRQ]) begin
          d.ud = UD_IDLE;
        end else if (!q.pin[PIN_DMARQ]) begin
          d.ud = UD_WATCH;
        end
      end
      UD_WATCH: begin
        if (q.pin[PIN_INTRQ]) begin
          d.ud = UD_IDLE;
        end else if (q.pin[PIN_DMARQ]) begin
          d.ud = UD_IDLE;
          ovr_set = 1'b1;
        end
      end
      default: begin
        d.ud = UD_IDLE;
      end
    endcase

    // Overrun bit: write one or launch clears, set wins
    ovr_clr = command_launch_i
              || (xwr_i && xaddr_i == ADDR_STATUS && xwdata_i[BIT_OVR]);
    if (ovr_set) begin
      d.ovr = 1'b1;
    end else if (ovr_clr) begin
      d.ovr = 1'b0;
    end

    // Mismatch report toward primary flags
    d.mis = ovr_set || xfer_mismatch_i;

    // Read data, one cycle after the strobe
    if (xrd_i) begin
      if (xaddr_i == ADDR_FLAGS) begin
        d.rdata = {RSV_HIGH, q.flags};
      end else if (xaddr_i == ADDR_MASK) begin
        d.rdata = {4'h0, q.mask};
      end else if (xaddr_i == ADDR_STATUS) begin
        d.rdata = {4'h0, q.pin, q.ovr};
      end else begin
        d.rdata = RDATA_RST;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.sy1        <= PINS_RST;
      q.sy2        <= PINS_RST;
      q.sy3        <= PINS_RST;
      q.pin        <= PINS_RST;
      q.flags      <= FLAGS_RST;
      q.mask       <= MASK_RST;
      q.ovr        <= 1'b0;
      q.pkt_wait   <= 1'b0;
      q.intrq_seen <= 1'b0;
      q.ud         <= UD_IDLE;
      q.rdata      <= RDATA_RST;
      q.mis        <= 1'b0;
      q.go         <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign xrdata_o              = q.rdata;
  assign launch_go_o           = q.go;
  assign byte_count_mismatch_o = q.mis;
  assign secondary_pending_o   = |(q.flags & q.mask);
  assign irq_o                 = |(q.flags & q.mask);
  assign udma_pause_o          = (q.ud != UD_IDLE);
  assign udma_stop_o           = (q.ud != UD_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_nda;
    @(posedge clk_i) disable iff (rst_i)
    nondata_cfg_i && cmd_issue_i && drive_data_active_i |=> q.flags[BIT_NDA];
  endproperty
  a_nda: assert property (p_nda) else $error("nondata mismatch not flagged");

  property p_dseq;
    @(posedge clk_i) disable iff (rst_i)
    packet_mode_i && data_phase_i && seq_violation_i |=> q.flags[BIT_DSEQ];
  endproperty
  a_dseq: assert property (p_dseq) else $error("data sequence error lost");

  property p_seq;
    @(posedge clk_i) disable iff (rst_i)
    cmd_wr_i && packet_mode_i && full_auto_i && cmd_code_i == PACKET_CMD
    ##1 (packet_mode_i && full_auto_i && seq_violation_i && !packet_sent_i
    && !command_launch_i) |=> q.flags[BIT_SEQ];
  endproperty
  a_seq: assert property (p_seq) else $error("command sequence error lost");

  property p_bsy;
    @(posedge clk_i) disable iff (rst_i)
    command_launch_i && drive_busy_i && auto_cmd_mode_i
    |=> q.flags[BIT_BSY] && !launch_go_o;
  endproperty
  a_bsy: assert property (p_bsy) else $error("busy launch not blocked");

  property p_mirror;
    @(posedge clk_i) disable iff (rst_i)
    xrd_i && xaddr_i == ADDR_STATUS
    |=> xrdata_o[3:1] == $past(q.pin) && xrdata_o[7:4] == 4'h0;
  endproperty
  a_mirror: assert property (p_mirror) else $error("pin mirror wrong");

  property p_pio;
    @(posedge clk_i) disable iff (rst_i)
    pio_auto_i && q.intrq_seen && status_rd_i && status_drq_i
    |=> q.ovr && byte_count_mismatch_o;
  endproperty
  a_pio: assert property (p_pio) else $error("pio overrun not set");

  property p_pause;
    @(posedge clk_i) disable iff (rst_i)
    q.ud == UD_IDLE && udma_read_i && udma_overrun_i |=> udma_pause_o && udma_stop_o;
  endproperty
  a_pause: assert property (p_pause) else $error("udma not paused");

  property p_intrq_wins;
    @(posedge clk_i) disable iff (rst_i)
    q.ud == UD_WATCH && q.pin[PIN_INTRQ] && !q.ovr && !length_exceeded_i
    && !pio_auto_i |=> !q.ovr && !udma_pause_o;
  endproperty
  a_intrq_wins: assert property (p_intrq_wins) else $error("overrun set after intrq");

  property p_mis;
    @(posedge clk_i) disable iff (rst_i)
    $rose(q.ovr) |-> byte_count_mismatch_o;
  endproperty
  a_mis: assert property (p_mis) else $error("overrun without mismatch");

  property p_ovr_clr;
    @(posedge clk_i) disable iff (rst_i)
    command_launch_i && !length_exceeded_i && !pio_auto_i && q.ud == UD_IDLE
    |=> !q.ovr;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("launch did not clear overrun");

  property p_rsv;
    @(posedge clk_i) disable iff (rst_i)
    xrd_i && xaddr_i == ADDR_FLAGS |=> xrdata_o[7:4] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    q.flags[BIT_BSY] && !(xwr_i && xaddr_i == ADDR_FLAGS) |=> q.flags[BIT_BSY];
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    xwr_i && xaddr_i == ADDR_MASK && xwdata_i[3:0] == 4'h0 |=> !irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("masked flag raised irq");

endmodule // aes_flags

// ==== logic/aes_pkg.sv ====
package aes_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_FLAGS  = 16'hF0E8;  // Secondary interrupt flags
  localparam logic [15:0] ADDR_MASK   = 16'hF0E9;  // Secondary interrupt mask
  localparam logic [15:0] ADDR_STATUS = 16'hF0EA;  // Interface status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_NDA   = 0;  // Nondata command mismatch
  localparam int BIT_DSEQ  = 1;  // Packet data sequence error
  localparam int BIT_SEQ   = 2;  // Packet command sequence error
  localparam int BIT_BSY   = 3;  // Drive busy at launch
  localparam int BIT_OVR   = 0;  // Status: drive overrun
  localparam int PIN_DMARQ = 0;  // Pin vector positions
  localparam int PIN_DMACK = 1;
  localparam int PIN_INTRQ = 2;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FLAGS_RST   = 4'h0;
  localparam logic [3:0] MASK_RST    = 4'h0;
  localparam logic [2:0] PINS_RST    = 3'h0;
  localparam logic [3:0] RSV_HIGH    = 4'h0;   // Upper nibble readback
  localparam logic [7:0] RDATA_RST   = 8'h00;
  localparam logic [7:0] PACKET_CMD  = 8'hA0;  // Packet command code

  // Ultra DMA overrun handling
  typedef enum logic [1:0] {
    UD_IDLE,
    UD_PAUSE,
    UD_WATCH
  } aes_ud_t;

endpackage

// ==== tb/aes_drive_model.sv ====
// Drive side pins, answering at once or a few cycles late
module aes_drive_model (
  input  wire logic       clk_i,
  input  wire logic [2:0] want_i,   // {intrq, dmack_n, dmarq} to show
  input  wire logic       slow_i,   // Late answer
  output logic            dmarq_o,
  output logic            dmack_n_o,
  output logic            intrq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] d1_q = 3'h2;
  logic [2:0] d2_q = 3'h2;
  // --------------------------------------------
  // Pin delay line
  // --------------------------------------------
  always @(posedge clk_i) begin
    d1_q <= want_i;
    d2_q <= d1_q;
  end
  // Request and interrupt lines as the drive drives them
  assign {intrq_o, dmack_n_o, dmarq_o} = slow_i ? d2_q : want_i;
endmodule // aes_drive_model

// ==== tb/aes_flags_tb_top.sv ====
module aes_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import aes_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, xwr = 1'b0, xrd = 1'b0, slow = 1'b0;
  logic [15:0] xaddr = 16'h0000;
  logic [7:0]  xwdata = 8'h00, cmd_code = 8'h00, xrdata, v;
  logic [9:0]  lv = '0;
  logic [8:0]  ev = '0;
  logic [2:0]  want = 3'h2;
  logic dmarq, dmack_n, intrq, go, bcm, pend, irq, pause, stop;
  int failures = 0, compares = 0;
  initial forever #5 clk_i = ~clk_i;
  aes_drive_model u_drv (.clk_i(clk_i), .want_i(want), .slow_i(slow), .dmarq_o(dmarq),
    .dmack_n_o(dmack_n), .intrq_o(intrq));
  aes_flags u_dut (.clk_i(clk_i), .rst_i(rst_i), .xaddr_i(xaddr), .xwr_i(xwr), .xrd_i(xrd),
    .xwdata_i(xwdata), .xrdata_o(xrdata), .dmarq_i(dmarq), .dmack_n_i(dmack_n),
    .intrq_i(intrq), .command_launch_i(ev[7]), .auto_cmd_mode_i(lv[0]),
    .drive_busy_i(lv[1]), .nondata_cfg_i(lv[2]), .cmd_issue_i(ev[0]),
    .drive_data_active_i(lv[3]), .packet_mode_i(lv[4]), .full_auto_i(lv[5]),
    .data_phase_i(lv[6]), .seq_violation_i(ev[1]), .cmd_wr_i(ev[2]), .cmd_code_i(cmd_code),
    .packet_sent_i(ev[3]), .length_exceeded_i(ev[4]), .xfer_mismatch_i(ev[8]),
    .pio_auto_i(lv[7]), .status_rd_i(ev[5]), .status_drq_i(lv[8]), .udma_read_i(lv[9]),
    .udma_overrun_i(ev[6]), .launch_go_o(go), .byte_count_mismatch_o(bcm),
    .secondary_pending_o(pend), .irq_o(irq), .udma_pause_o(pause), .udma_stop_o(stop));
  // --------------------------------------------
  // Bus and compare helpers
  // --------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i); xaddr <= a; xwdata <= d; xwr <= 1'b1;
    @(posedge clk_i); xwr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i); xaddr <= a; xrd <= 1'b1;
    @(posedge clk_i); xrd <= 1'b0;
    #1 v = xrdata;
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i); ev[i] <= 1'b1;
    @(posedge clk_i); ev <= '0;
    #1;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // --------------------------------------------
  // Scenarios
  // --------------------------------------------
  task automatic t_reset();
    rd(ADDR_FLAGS); chk(v, 8'h00);
    rd(ADDR_MASK); chk(v, 8'h00);
    rd(16'hF0EB); chk(v, 8'h00);
  endtask
  task automatic t_nda();
    @(posedge clk_i); lv <= 10'h00C;
    pulse(0); rd(ADDR_FLAGS); chk(v, 8'h01);
    @(posedge clk_i); lv <= '0;
    rd(ADDR_FLAGS); chk(v, 8'h01);
    wr(ADDR_FLAGS, 8'hFF); rd(ADDR_FLAGS); chk(v, 8'h00);
  endtask
  task automatic t_seq();
    @(posedge clk_i); lv <= 10'h050;
    pulse(1); rd(ADDR_FLAGS); chk(v, 8'h02);
    @(posedge clk_i); lv <= 10'h030; cmd_code <= PACKET_CMD;
    // Violation in the cycle right after the packet command write
    @(posedge clk_i); ev <= 9'h004;
    @(posedge clk_i); ev <= 9'h002;
    @(posedge clk_i); ev <= '0;
    rd(ADDR_FLAGS); chk(v, 8'h06);
    // Firmware quizzes the drive before clearing
    repeat (2) @(posedge clk_i);
    wr(ADDR_FLAGS, 8'h06);
    // Packet bytes sent close the window
    pulse(2); pulse(3); pulse(1); rd(ADDR_FLAGS); chk(v, 8'h00);
    @(posedge clk_i); lv <= '0;
  endtask
  task automatic t_bsy();
    @(posedge clk_i); lv <= 10'h003;
    pulse(7); chk(go, 1'b0);
    rd(ADDR_FLAGS); chk(v, 8'h08);
    chk(irq, 1'b0);
    wr(ADDR_MASK, 8'hFF); #1 chk({pend, irq}, 2'h3);
    rd(ADDR_MASK); chk(v, 8'h0F);
    wr(ADDR_MASK, 8'h00); #1 chk({pend, irq}, 2'h0);
    wr(ADDR_MASK, 8'h0F);
    @(posedge clk_i); lv <= 10'h001;
    pulse(7); chk(go, 1'b1);
    // Busy outside automatic command mode still launches
    @(posedge clk_i); lv <= 10'h002;
    pulse(7); chk(go, 1'b1);
    // Firmware reads the drive task file before clearing
    repeat (2) @(posedge clk_i);
    wr(ADDR_FLAGS, 8'h08); #1 chk(irq, 1'b0);
  endtask
  task automatic t_pins();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i); want <= i[2:0]; slow <= i[0];
      repeat (8) @(posedge clk_i);
      rd(ADDR_STATUS); chk(v, {4'h0, i[2:0], 1'b0});
    end
    @(posedge clk_i); want <= 3'h2; slow <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic t_ovr();
    pulse(4); chk(bcm, 1'b1);
    rd(ADDR_STATUS); chk(v, 8'h05);
    wr(ADDR_STATUS, 8'h01); rd(ADDR_STATUS); chk(v, 8'h04);
    pulse(4); pulse(7); rd(ADDR_STATUS); chk(v, 8'h04);
    pulse(8); chk(bcm, 1'b1);
  endtask
  task automatic t_pio();
    @(posedge clk_i); lv <= 10'h080; want <= 3'h6;
    repeat (6) @(posedge clk_i);
    lv <= 10'h180;
    pulse(5); rd(ADDR_STATUS); chk(v, 8'h0D);
    wr(ADDR_STATUS, 8'h01); @(posedge clk_i); lv <= '0; want <= 3'h2;
  endtask
  task automatic t_udma();
    @(posedge clk_i); lv <= 10'h200; want <= 3'h3; slow <= 1'b1;
    repeat (6) @(posedge clk_i);
    pulse(6); @(posedge clk_i); #1 chk({pause, stop}, 2'h3);
    want <= 3'h2; repeat (8) @(posedge clk_i);
    #1 chk({pause, stop}, 2'h3);
    want <= 3'h3; repeat (10) @(posedge clk_i);
    #1 chk({pause, stop}, 2'h0);
    rd(ADDR_STATUS); chk(v, 8'h07);
    wr(ADDR_STATUS, 8'h01);
    // Request drops, then interrupt arrives while watching
    pulse(6); @(posedge clk_i); want <= 3'h2; repeat (8) @(posedge clk_i);
    #1 chk({pause, stop}, 2'h3);
    want <= 3'h6; repeat (10) @(posedge clk_i);
    #1 chk({pause, stop}, 2'h0);
    rd(ADDR_STATUS); chk(v, 8'h0C);
  endtask
  task automatic t_rst();
    @(posedge clk_i); lv <= 10'h003;
    pulse(7); chk(irq, 1'b1);
    // Reset in mid-run wipes flags and mask
    @(posedge clk_i); rst_i <= 1'b1; lv <= '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk({pend, irq, go}, 3'h0);
    rd(ADDR_FLAGS); chk(v, 8'h00);
    rd(ADDR_MASK); chk(v, 8'h00);
  endtask
  // --------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset(); t_nda(); t_seq(); t_bsy(); t_pins(); t_ovr(); t_pio(); t_udma(); t_rst();
    give_verdict();
  end
  initial begin
    #100us;
    failures++;
    give_verdict();
  end
endmodule // aes_flags_tb_top
